// file: design/bsd_pkg.sv
// shared constants, field layouts and carrier types of the bitstream detect / master clock block
package bsd_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int BSD_CLK_HZ = 100_000_000;
  localparam int BSD_FS_MIN_HZ = 32000;
  localparam int BSD_FS_MAX_HZ = 192000;
  localparam int BSD_TOL_PCT = 3;
  // frame period window in mclk cycles, widened by the tolerance
  localparam int BSD_IV_MIN = (BSD_CLK_HZ / BSD_FS_MAX_HZ) * (100 - BSD_TOL_PCT) / 100;
  localparam int BSD_IV_MAX = ((BSD_CLK_HZ + BSD_FS_MIN_HZ - 1) / BSD_FS_MIN_HZ) * (100 + BSD_TOL_PCT) / 100;
  localparam int BSD_LOCK_MS = 20;
  localparam int BSD_LOCK_CYC = BSD_LOCK_MS * (BSD_CLK_HZ / 1000);
  localparam int BSD_LOCK_FRAMES = 4;
  localparam int BSD_FRAME_HOLD = 4096;

  // ****************************************************************
  // burst sync code
  // ****************************************************************
  localparam int BSD_ZERO_WORDS = 4;
  localparam logic [15:0] BSD_SYNC_PA = 16'hf872;
  localparam logic [15:0] BSD_SYNC_PB = 16'h4e1f;
  localparam logic [15:0] BSD_CDS_SYNC_A = 16'h7ffe;
  localparam logic [15:0] BSD_CDS_SYNC_B = 16'h8001;

  // ****************************************************************
  // sampling frequency codes and period thresholds (cycles)
  // ****************************************************************
  localparam logic [3:0] BSD_FS_441 = 4'h0;
  localparam logic [3:0] BSD_FS_RSVD = 4'h1;
  localparam logic [3:0] BSD_FS_48 = 4'h2;
  localparam logic [3:0] BSD_FS_32 = 4'h3;
  localparam logic [3:0] BSD_FS_882 = 4'h8;
  localparam logic [3:0] BSD_FS_96 = 4'ha;
  localparam logic [3:0] BSD_FS_1764 = 4'hc;
  localparam logic [3:0] BSD_FS_192 = 4'he;
  localparam logic [11:0] BSD_TH_192 = 12'h220;
  localparam logic [11:0] BSD_TH_1764 = 12'h324;
  localparam logic [11:0] BSD_TH_96 = 12'h440;
  localparam logic [11:0] BSD_TH_882 = 12'h648;
  localparam logic [11:0] BSD_TH_48 = 12'h87f;
  localparam logic [11:0] BSD_TH_441 = 12'ha88;
  localparam logic [3:0] BSD_XTAL_FS = BSD_FS_48;

  // nco increments for a 64fs output toggling at 128fs, per fs code
  localparam logic [31:0] BSD_INC_32 = 32'h0a7c5ac4;
  localparam logic [31:0] BSD_INC_441 = 32'h0e73604a;
  localparam logic [31:0] BSD_INC_48 = 32'h0fba8827;
  localparam logic [31:0] BSD_INC_882 = 32'h1ce6c094;
  localparam logic [31:0] BSD_INC_96 = 32'h1f75104d;
  localparam logic [31:0] BSD_INC_1764 = 32'h39cd8128;
  localparam logic [31:0] BSD_INC_192 = 32'h3eea209b;

  // ****************************************************************
  // clock operation modes
  // ****************************************************************
  localparam logic [1:0] BSD_CM_RECOV = 2'h0;
  localparam logic [1:0] BSD_CM_XTAL = 2'h1;
  localparam logic [1:0] BSD_CM_AUTO = 2'h2;
  localparam logic [1:0] BSD_CM_XTAL_MON = 2'h3;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] BSD_REG_FLAGS = 8'h00;
  localparam logic [7:0] BSD_REG_PC = 8'h04;
  localparam logic [7:0] BSD_REG_PD = 8'h08;
  localparam logic [7:0] BSD_REG_CTRL = 8'h0c;
  localparam logic [7:0] BSD_REG_IRQ_ST = 8'h10;
  localparam logic [7:0] BSD_REG_IRQ_CLR = 8'h14;
  localparam logic [7:0] BSD_REG_IRQ_EN = 8'h18;
  localparam int BSD_FLG_NONPCM = 0;
  localparam int BSD_FLG_CDS = 1;
  localparam int BSD_FLG_LOCK = 2;
  localparam int BSD_FLG_XTAL = 3;
  localparam int BSD_FLG_FS = 4;
  localparam int BSD_CTRL_FS_CS = 0;
  localparam int BSD_EV_NONPCM = 0;
  localparam int BSD_EV_CDS = 1;
  localparam int BSD_EV_UNLOCK = 2;
  localparam int BSD_EV_FS = 3;
  localparam int BSD_EV_W = 4;
  localparam logic BSD_CTRL_RST = 1'b0;
  localparam logic [3:0] BSD_IRQ_EN_RST = 4'h0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic frame;
    logic [15:0] data;
  } bsd_rx_word_s;

  typedef struct packed {
    logic run;
    logic [3:0] fs_code;
    logic [1:0] sel;
  } bsd_mck_cfg_s;

endpackage

// file: design/bsd_mck_gen.sv
// master clock output generator: two nco outputs at selected fs multiples
`timescale 1ns/1ps
`default_nettype none
module bsd_mck_gen
  import bsd_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire bsd_mck_cfg_s cfg,
  output logic mck_a,
  output logic mck_b
);

  logic [31:0] acc_a_ff, acc_b_ff, nxt_acc_a, nxt_acc_b;
  logic mck_a_ff, mck_b_ff, nxt_mck_a, nxt_mck_b;
  logic [1:0] sh_a, sh_b;
  logic ok_a, ok_b;
  logic [32:0] sum_a, sum_b;

  // nco step for the 64fs rate of a given fs code
  function automatic logic [31:0] inc_of(input logic [3:0] fs);
    if (fs == BSD_FS_32) inc_of = BSD_INC_32;
    else if (fs == BSD_FS_441) inc_of = BSD_INC_441;
    else if (fs == BSD_FS_48) inc_of = BSD_INC_48;
    else if (fs == BSD_FS_882) inc_of = BSD_INC_882;
    else if (fs == BSD_FS_96) inc_of = BSD_INC_96;
    else if (fs == BSD_FS_1764) inc_of = BSD_INC_1764;
    else if (fs == BSD_FS_192) inc_of = BSD_INC_192;
    else inc_of = 32'h0;
  endfunction

  // a shift of 3 means 512fs, 2 means 256fs; 512fs is barred from 88.2 khz up, 256fs from 176.4 khz up
  function automatic logic rate_ok(input logic [1:0] sh, input logic [3:0] fs);
    rate_ok = !((sh == 2'h3) && fs[3]) && !((sh == 2'h2) && (fs[3:2] == 2'h3));
  endfunction

  // ****************************************************************
  // multiplier select and nco
  // ****************************************************************
  always_comb begin
    case (cfg.sel) // [RL10]
      2'h0: begin sh_a = 2'h2; sh_b = 2'h2; end
      2'h1: begin sh_a = 2'h2; sh_b = 2'h1; end
      2'h2: begin sh_a = 2'h3; sh_b = 2'h2; end
      default: begin sh_a = 2'h1; sh_b = 2'h0; end
    endcase
    ok_a = cfg.run && rate_ok(sh_a, cfg.fs_code); // [RL11]
    ok_b = cfg.run && rate_ok(sh_b, cfg.fs_code); // [RL11]
    sum_a = {1'b0, acc_a_ff} + {1'b0, inc_of(cfg.fs_code) << sh_a};
    sum_b = {1'b0, acc_b_ff} + {1'b0, inc_of(cfg.fs_code) << sh_b};
    // a barred or stopped output is parked low rather than run at a wrong rate
    nxt_acc_a = ok_a ? sum_a[31:0] : 32'h0;
    nxt_acc_b = ok_b ? sum_b[31:0] : 32'h0;
    nxt_mck_a = ok_a ? (mck_a_ff ^ sum_a[32]) : 1'b0;
    nxt_mck_b = ok_b ? (mck_b_ff ^ sum_b[32]) : 1'b0;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc_a_ff <= 32'h0;
      acc_b_ff <= 32'h0;
      mck_a_ff <= 1'b0;
      mck_b_ff <= 1'b0;
    end else begin
      acc_a_ff <= nxt_acc_a;
      acc_b_ff <= nxt_acc_b;
      mck_a_ff <= nxt_mck_a;
      mck_b_ff <= nxt_mck_b;
    end
  end

  assign mck_a = mck_a_ff;
  assign mck_b = mck_b_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_NO_512_HIGH: assert property ((cfg.sel == 2'h2) && cfg.fs_code[3] |=> !mck_a_ff) // [RL11]
    else $error("512fs output ran at a high sampling rate");
  AST_NO_256_TOP: assert property ((cfg.sel == 2'h0) && (cfg.fs_code[3:2] == 2'h3) |=> !mck_b_ff) // [RL11]
    else $error("256fs output ran at a top sampling rate");
  AST_STOP_LOW: assert property (!cfg.run |=> !mck_a_ff && !mck_b_ff) // [RL9]
    else $error("master clocks ran without a clock source");
  COV_MODE3: cover property ((cfg.sel == 2'h3) && cfg.run ##1 $rose(mck_b_ff));

endmodule
`default_nettype wire

// file: design/bsd_top.sv
// bitstream detection, lock / fs detection, clock source select and register file
// Summary of operation
// RL1 - the non-pcm flag sets when four zero words followed by f872 and 4e1f are seen in the data words.
// RL2 - once set, the non-pcm flag holds until 4096 consecutive frames pass with no further burst sync.
// RL3 - every burst sync capture stores the two words that follow it as the pc and pd preambles.
// RL4 - the cd surround flag sets when that bitstream's sync code is seen in the data words.
// RL5 - the cd surround flag clears after 4096 frames without a new sync and stays clear until the next one.
// RL6 - lock is declared on frame periods from 32 khz to 192 khz after a few frames, well inside 20 ms.
// RL7 - the fs code is taken from the measured frame period or from the channel status field.
// RL8 - a frame period that is out of range or differs from the last one by more than 1/32 of it drops lock.
// RL9 - both master clock outputs run from the selected source, recovered rate or crystal.
// RL10 - the two-bit output clock select picks 256/256, 256/128, 512/256 or 128/64 fs.
// RL11 - 512fs is never produced at 88.2 khz and above, 256fs never at 176.4 khz and above.
// RL12 - in the automatic mode the source falls back to the crystal while unlocked.
// RL13 - each hold-off frame counter restarts on every detection and reset clears both flags.
`timescale 1ns/1ps
`default_nettype none
module bsd_top
  import bsd_pkg::*;
#(
  parameter int FRAME_HOLD = BSD_FRAME_HOLD,
  parameter int LOCK_FRAMES = BSD_LOCK_FRAMES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire bsd_rx_word_s rx_word,
  input wire logic [3:0] cs_fs_code,
  input wire logic out_clock_sel_lo,
  input wire logic out_clock_sel_hi,
  input wire logic clock_op_mode_lo,
  input wire logic clock_op_mode_hi,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic nonpcm_flag,
  output logic cd_surround_detected_flag,
  output logic pll_locked,
  output logic master_clock_out_a,
  output logic master_clock_out_b
);

  localparam int HW = $clog2(FRAME_HOLD);
  localparam logic [HW-1:0] HOLD_LAST = HW'(FRAME_HOLD - 1);
  localparam logic [11:0] IV_MIN = 12'(BSD_IV_MIN);
  localparam logic [11:0] IV_MAX = 12'(BSD_IV_MAX);
  localparam logic [2:0] GOOD_LAST = 3'(LOCK_FRAMES - 1);

  typedef enum logic [1:0] {BST_HUNT, BST_SYNC, BST_PC, BST_PD} bsd_bst_e;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0] pin_s1_ff, pin_s2_ff, nxt_pin_s1;
  logic [1:0] ocks, cmode;

  // mode straps are asynchronous pins; the first stage feeds only the second
  always_comb begin
    nxt_pin_s1 = {out_clock_sel_hi, out_clock_sel_lo, clock_op_mode_hi, clock_op_mode_lo};
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
    end else begin
      pin_s1_ff <= nxt_pin_s1;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign ocks = pin_s2_ff[3:2];
  assign cmode = pin_s2_ff[1:0];

  // ****************************************************************
  // burst sync and cd surround sync search
  // ****************************************************************
  bsd_bst_e bst_st_ff, nxt_bst_st;
  logic [2:0] zcnt_ff, nxt_zcnt;
  logic [15:0] pc_ff, pd_ff, nxt_pc, nxt_pd, cds_prev_ff, nxt_cds_prev;
  logic bst_hit, cds_hit;

  always_comb begin
    nxt_bst_st = bst_st_ff;
    nxt_zcnt = zcnt_ff;
    nxt_pc = pc_ff;
    nxt_pd = pd_ff;
    nxt_cds_prev = cds_prev_ff;
    bst_hit = 1'b0;
    cds_hit = 1'b0;
    if (rx_word.valid) begin
      nxt_cds_prev = rx_word.data;
      cds_hit = (cds_prev_ff == BSD_CDS_SYNC_A) && (rx_word.data == BSD_CDS_SYNC_B); // [RL4]
      case (bst_st_ff)
        BST_HUNT: begin
          if (rx_word.data == 16'h0) begin
            nxt_zcnt = (zcnt_ff == 3'(BSD_ZERO_WORDS)) ? zcnt_ff : zcnt_ff + 3'h1;
          end else begin
            nxt_zcnt = 3'h0;
            if ((rx_word.data == BSD_SYNC_PA) && (zcnt_ff == 3'(BSD_ZERO_WORDS))) begin
              nxt_bst_st = BST_SYNC;
            end
          end
        end
        BST_SYNC: begin
          if (rx_word.data == BSD_SYNC_PB) begin
            nxt_bst_st = BST_PC;
            bst_hit = 1'b1; // [RL1]
          end else begin
            nxt_bst_st = BST_HUNT;
            nxt_zcnt = (rx_word.data == 16'h0) ? 3'h1 : 3'h0;
          end
        end
        BST_PC: begin
          nxt_pc = rx_word.data; // [RL3]
          nxt_bst_st = BST_PD;
        end
        default: begin
          nxt_pd = rx_word.data; // [RL3]
          nxt_bst_st = BST_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bst_st_ff <= BST_HUNT;
      zcnt_ff <= 3'h0;
      pc_ff <= 16'h0;
      pd_ff <= 16'h0;
      cds_prev_ff <= 16'h0;
    end else begin
      bst_st_ff <= nxt_bst_st;
      zcnt_ff <= nxt_zcnt;
      pc_ff <= nxt_pc;
      pd_ff <= nxt_pd;
      cds_prev_ff <= nxt_cds_prev;
    end
  end

  // ****************************************************************
  // detection flags with frame hold-off
  // ****************************************************************
  logic np_ff, cd_ff, nxt_np, nxt_cd;
  logic [HW-1:0] np_cnt_ff, cd_cnt_ff, nxt_np_cnt, nxt_cd_cnt;
  logic frm;

  assign frm = rx_word.valid && rx_word.frame;

  always_comb begin
    nxt_np = np_ff;
    nxt_np_cnt = np_cnt_ff;
    nxt_cd = cd_ff;
    nxt_cd_cnt = cd_cnt_ff;
    // a fresh detection wins over an expiring count in the same cycle
    if (bst_hit) begin
      nxt_np = 1'b1; // [RL1]
      nxt_np_cnt = '0; // [RL13]
    end else if (frm && np_ff) begin
      nxt_np = (np_cnt_ff != HOLD_LAST); // [RL2]
      nxt_np_cnt = (np_cnt_ff == HOLD_LAST) ? '0 : np_cnt_ff + 1'b1;
    end
    if (cds_hit) begin
      nxt_cd = 1'b1; // [RL4]
      nxt_cd_cnt = '0; // [RL13]
    end else if (frm && cd_ff) begin
      nxt_cd = (cd_cnt_ff != HOLD_LAST); // [RL5]
      nxt_cd_cnt = (cd_cnt_ff == HOLD_LAST) ? '0 : cd_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      np_ff <= 1'b0; // [RL13]
      cd_ff <= 1'b0; // [RL13]
      np_cnt_ff <= '0;
      cd_cnt_ff <= '0;
    end else begin
      np_ff <= nxt_np;
      cd_ff <= nxt_cd;
      np_cnt_ff <= nxt_np_cnt;
      cd_cnt_ff <= nxt_cd_cnt;
    end
  end

  // ****************************************************************
  // frame period lock, fs measurement and clock source
  // ****************************************************************
  logic [11:0] iv_ff, prev_iv_ff, nxt_iv, nxt_prev_iv, iv_diff;
  logic [2:0] good_ff, nxt_good;
  logic lock_ff, nxt_lock, src_xtal_ff, nxt_src_xtal, iv_ok;
  logic [3:0] fs_meas_ff, nxt_fs_meas;
  logic [3:0] fs_rep_ff, nxt_fs_rep;
  bsd_mck_cfg_s mck_cfg_ff, nxt_mck_cfg;

  // nearest standard rate for a frame period in mclk cycles
  function automatic logic [3:0] fs_of_iv(input logic [11:0] iv);
    if (iv < BSD_TH_192) fs_of_iv = BSD_FS_192;
    else if (iv < BSD_TH_1764) fs_of_iv = BSD_FS_1764;
    else if (iv < BSD_TH_96) fs_of_iv = BSD_FS_96;
    else if (iv < BSD_TH_882) fs_of_iv = BSD_FS_882;
    else if (iv < BSD_TH_48) fs_of_iv = BSD_FS_48;
    else if (iv < BSD_TH_441) fs_of_iv = BSD_FS_441;
    else fs_of_iv = BSD_FS_32;
  endfunction

  always_comb begin
    iv_diff = (iv_ff > prev_iv_ff) ? iv_ff - prev_iv_ff : prev_iv_ff - iv_ff;
    iv_ok = (iv_ff >= IV_MIN) && (iv_ff <= IV_MAX) && (iv_diff <= (prev_iv_ff >> 5)); // [RL8]
    nxt_iv = (iv_ff > IV_MAX) ? iv_ff : iv_ff + 12'h1;
    nxt_prev_iv = prev_iv_ff;
    nxt_good = good_ff;
    nxt_lock = lock_ff;
    nxt_fs_meas = fs_meas_ff;
    if (frm) begin
      nxt_iv = 12'h1;
      nxt_prev_iv = iv_ff;
      if (iv_ok) begin
        nxt_good = (good_ff == GOOD_LAST) ? good_ff : good_ff + 3'h1;
        if (good_ff == GOOD_LAST) begin
          nxt_lock = 1'b1; // [RL6]
          nxt_fs_meas = fs_of_iv(iv_ff); // [RL7]
        end
      end else begin
        nxt_good = 3'h0;
        nxt_lock = 1'b0; // [RL8]
      end
    end else if (iv_ff > IV_MAX) begin
      // a missing frame pulse is an incorrect interval too
      nxt_good = 3'h0;
      nxt_lock = 1'b0; // [RL8]
    end
    case (cmode)
      BSD_CM_RECOV: nxt_src_xtal = 1'b0; // [RL9]
      BSD_CM_AUTO: nxt_src_xtal = !lock_ff; // [RL12]
      default: nxt_src_xtal = 1'b1; // [RL9]
    endcase
    nxt_mck_cfg.sel = ocks; // [RL10]
    nxt_mck_cfg.fs_code = src_xtal_ff ? BSD_XTAL_FS : fs_rep_ff; // [RL9]
    nxt_mck_cfg.run = src_xtal_ff || lock_ff;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      iv_ff <= 12'h0;
      prev_iv_ff <= 12'h0;
      good_ff <= 3'h0;
      lock_ff <= 1'b0;
      fs_meas_ff <= BSD_FS_RSVD;
      src_xtal_ff <= 1'b0;
      mck_cfg_ff <= '0;
    end else begin
      iv_ff <= nxt_iv;
      prev_iv_ff <= nxt_prev_iv;
      good_ff <= nxt_good;
      lock_ff <= nxt_lock;
      fs_meas_ff <= nxt_fs_meas;
      src_xtal_ff <= nxt_src_xtal;
      mck_cfg_ff <= nxt_mck_cfg;
    end
  end

  bsd_mck_gen u_mck (
    .mclk(mclk),
    .nrst(nrst),
    .cfg(mck_cfg_ff),
    .mck_a(master_clock_out_a),
    .mck_b(master_clock_out_b)
  );

  // ****************************************************************
  // register file and interrupt
  // ****************************************************************
  logic ctrl_ff, nxt_ctrl, irq_ff, nxt_irq, lock_d_ff;
  logic [BSD_EV_W-1:0] ist_ff, ien_ff, nxt_ist, nxt_ien, ev, clr;
  logic [31:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ien = ien_ff;
    clr = '0;
    if (reg_wr) begin
      if (reg_addr == BSD_REG_CTRL) nxt_ctrl = reg_wdata[BSD_CTRL_FS_CS];
      else if (reg_addr == BSD_REG_IRQ_EN) nxt_ien = reg_wdata[BSD_EV_W-1:0];
      else if (reg_addr == BSD_REG_IRQ_CLR) clr = reg_wdata[BSD_EV_W-1:0];
    end
    nxt_fs_rep = ctrl_ff ? cs_fs_code : fs_meas_ff; // [RL7]
    ev = '0;
    ev[BSD_EV_NONPCM] = nxt_np && !np_ff;
    ev[BSD_EV_CDS] = nxt_cd && !cd_ff;
    ev[BSD_EV_UNLOCK] = lock_d_ff && !lock_ff;
    ev[BSD_EV_FS] = nxt_fs_rep != fs_rep_ff;
    // an event in the clearing cycle survives the clear
    nxt_ist = (ist_ff & ~clr) | ev;
    nxt_irq = |(nxt_ist & nxt_ien);
    nxt_rdata = 32'h0;
    if (reg_rd) begin
      if (reg_addr == BSD_REG_FLAGS) begin
        nxt_rdata[BSD_FLG_NONPCM] = np_ff;
        nxt_rdata[BSD_FLG_CDS] = cd_ff;
        nxt_rdata[BSD_FLG_LOCK] = lock_ff;
        nxt_rdata[BSD_FLG_XTAL] = src_xtal_ff;
        nxt_rdata[BSD_FLG_FS +: 4] = fs_rep_ff;
      end else if (reg_addr == BSD_REG_PC) nxt_rdata[15:0] = pc_ff; // [RL3]
      else if (reg_addr == BSD_REG_PD) nxt_rdata[15:0] = pd_ff; // [RL3]
      else if (reg_addr == BSD_REG_CTRL) nxt_rdata[BSD_CTRL_FS_CS] = ctrl_ff;
      else if (reg_addr == BSD_REG_IRQ_ST) nxt_rdata[BSD_EV_W-1:0] = ist_ff;
      else if (reg_addr == BSD_REG_IRQ_EN) nxt_rdata[BSD_EV_W-1:0] = ien_ff;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= BSD_CTRL_RST;
      ien_ff <= BSD_IRQ_EN_RST;
      ist_ff <= '0;
      irq_ff <= 1'b0;
      lock_d_ff <= 1'b0;
      fs_rep_ff <= BSD_FS_RSVD;
      rdata_ff <= 32'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      ien_ff <= nxt_ien;
      ist_ff <= nxt_ist;
      irq_ff <= nxt_irq;
      lock_d_ff <= lock_ff;
      fs_rep_ff <= nxt_fs_rep;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;
  assign nonpcm_flag = np_ff;
  assign cd_surround_detected_flag = cd_ff;
  assign pll_locked = lock_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_NONPCM_SET: assert property (bst_st_ff == BST_SYNC && rx_word.valid && rx_word.data == BSD_SYNC_PB // [RL1]
    |=> np_ff)
    else $error("burst sync seen but non-pcm flag not set");
  AST_NONPCM_HOLD: assert property (np_ff && !(frm && np_cnt_ff == HOLD_LAST) |=> np_ff) // [RL2]
    else $error("non-pcm flag dropped before the hold-off ran out");
  AST_NONPCM_CLEAR: assert property (np_ff && !bst_hit && frm && np_cnt_ff == HOLD_LAST |=> !np_ff) // [RL2]
    else $error("non-pcm flag kept after the hold-off");
  AST_PD_WORD: assert property (bst_st_ff == BST_PD && rx_word.valid |=> // [RL3]
    pd_ff == $past(rx_word.data) && bst_st_ff == BST_HUNT)
    else $error("pd preamble not captured from the word after pc");
  AST_PC_WORD: assert property (bst_st_ff == BST_PC && rx_word.valid |=> // [RL3]
    pc_ff == $past(rx_word.data) && bst_st_ff == BST_PD)
    else $error("pc preamble not captured from the next word");
  AST_CD_SET: assert property (cds_hit |=> cd_ff && cd_cnt_ff == '0) // [RL4]
    else $error("cd surround sync seen but flag not set");
  AST_CD_CLEAR: assert property (cd_ff && !cds_hit && frm && cd_cnt_ff == HOLD_LAST |=> !cd_ff) // [RL5]
    else $error("cd surround flag kept after the hold-off");
  AST_RESTART: assert property (bst_hit |=> np_cnt_ff == '0) // [RL13]
    else $error("hold-off counter not restarted on detection");
  AST_UNLOCK: assert property (frm && !iv_ok |=> !lock_ff) // [RL8]
    else $error("lock kept after a bad frame period");
  AST_LOCK_CAUSE: assert property ($rose(lock_ff) |-> $past(frm) && $past(iv_ok)) // [RL6]
    else $error("lock declared without a good frame period");
  AST_FALLBACK: assert property (cmode == BSD_CM_AUTO && !lock_ff ##1 cmode == BSD_CM_AUTO |-> src_xtal_ff) // [RL12]
    else $error("automatic mode did not fall back to the crystal");
  AST_FS_SRC: assert property (ctrl_ff && !reg_wr |=> fs_rep_ff == $past(cs_fs_code)) // [RL7]
    else $error("fs code not taken from channel status");

  COV_NONPCM: cover property (bst_hit ##[1:20] rx_word.valid && bst_st_ff == BST_PD);
  COV_CD: cover property (cds_hit);
  COV_FALLBACK: cover property (cmode == BSD_CM_AUTO && $fell(lock_ff) ##2 src_xtal_ff);

endmodule
`default_nettype wire

// file: test/bsd_tx_model.sv
// transmitter model: one framed data word every 520 cycles (192 khz)
`timescale 1ns/1ps
`default_nettype none
module bsd_tx_model
  import bsd_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [15:0] word,
  output var bsd_rx_word_s rx_word
);
  int cnt;
  // between words the data toggles, so a stale word is never mistaken for a fresh one
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      rx_word <= '0;
    end else begin
      cnt <= (cnt == 519) ? 0 : cnt + 1;
      rx_word.valid <= run && cnt == 519;
      rx_word.frame <= run && cnt == 519;
      rx_word.data <= (run && cnt == 519) ? word : ~rx_word.data;
    end
  end
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the bitstream detect and master clock block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("Error %0t: mismatch", $time); end end
module tb;
  import bsd_pkg::*;
  logic mclk = 0, nrst = 0, run = 0, wr = 0, rd = 0, irq, fnp, fcd, lk, ma, mb;
  logic [1:0] sel = 0, cm = 0;
  logic [7:0] addr = 0;
  logic [15:0] word = 0;
  logic [31:0] wdata = 0, rdata, q;
  bsd_rx_word_s rx;
  int n_fail = 0, total_checks = 0, cyc = 0, na, nb;
  int ea[4] = '{123, 123, 246, 61}, eb[4] = '{123, 61, 123, 31};
  initial forever #5 mclk = ~mclk;
  // edge counters give output frequency per 1000 cycles
  always @(posedge ma) na++;
  always @(posedge mb) nb++;
  bsd_tx_model u_bsd_tx_model (.mclk(mclk), .nrst(nrst), .run(run), .word(word), .rx_word(rx));
  bsd_top #(.FRAME_HOLD(10), .LOCK_FRAMES(4)) u_bsd_top (.mclk(mclk), .nrst(nrst), .rx_word(rx),
    .cs_fs_code(BSD_FS_96), .out_clock_sel_lo(sel[0]), .out_clock_sel_hi(sel[1]), .clock_op_mode_lo(cm[0]),
    .clock_op_mode_hi(cm[1]), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .irq(irq), .nonpcm_flag(fnp), .cd_surround_detected_flag(fcd), .pll_locked(lk), .master_clock_out_a(ma),
    .master_clock_out_b(mb));
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    q = rdata;
  endtask
  // one word per frame; the extra edge lets the flags land
  task automatic sendq(input logic [15:0] ws[$]);
    foreach (ws[i]) begin
      word <= ws[i];
      @(posedge mclk iff rx.valid);
    end
    @(posedge mclk);
  endtask
  task automatic meas(input int a, input int b);
    repeat (20) @(posedge mclk);
    na = 0;
    nb = 0;
    repeat (1000) @(posedge mclk);
    `CHK(na inside {[a - 4:a + 4]}, 1'b1)
    `CHK(nb inside {[b - 4:b + 4]}, 1'b1)
  endtask
  task automatic test_done();
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // cut a hang short well above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      $display("Error %0t: timeout", $time);
      test_done();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    `CHK({fnp, fcd, lk}, 3'b000)
    wr_reg(BSD_REG_IRQ_EN, 32'h1);
    run <= 1'b1;
    sendq('{0, 0, 0, 0, 0});
    `CHK(lk, 1'b1)
    rd_reg(BSD_REG_FLAGS);
    `CHK(q[7:4], BSD_FS_192)
    // the reported code follows the control bit one cycle after it lands
    wr_reg(BSD_REG_CTRL, 32'h1);
    @(posedge mclk);
    rd_reg(BSD_REG_FLAGS);
    `CHK(q[7:4], BSD_FS_96)
    wr_reg(BSD_REG_CTRL, 32'h0);
    sendq('{16'hf872, 16'h4e1f});
    `CHK(fnp, 1'b1)
    `CHK(irq, 1'b1)
    wr_reg(BSD_REG_IRQ_CLR, 32'h1);
    @(posedge mclk);
    `CHK(irq, 1'b0)
    // a second burst inside the hold-off restarts its count; the first two words are the earlier pc and pd
    sendq('{0, 0, 0, 0, 0, 0, 16'hf872, 16'h4e1f, 16'h1234, 16'h5678});
    rd_reg(BSD_REG_PC);
    `CHK(q, 32'h1234)
    rd_reg(BSD_REG_PD);
    `CHK(q, 32'h5678)
    sendq('{0, 0, 0, 0, 0, 0, 0});
    `CHK(fnp, 1'b1)
    sendq('{0});
    `CHK(fnp, 1'b0)
    sendq('{16'h7ffe, 16'h8001});
    `CHK(fcd, 1'b1)
    sendq('{0, 0, 0, 0, 0, 0, 0, 0, 0, 0});
    `CHK(fcd, 1'b0)
    sel <= 2'h3;
    meas(246, 123);
    sel <= 2'h0;
    meas(0, 0);
    sel <= 2'h2;
    meas(0, 0);
    cm <= 2'h1;
    for (int s = 0; s < 4; s++) begin
      sel <= s[1:0];
      meas(ea[s], eb[s]);
    end
    cm <= 2'h2;
    sel <= 2'h0;
    run <= 1'b0;
    repeat (4000) @(posedge mclk);
    `CHK(lk, 1'b0)
    rd_reg(BSD_REG_FLAGS);
    `CHK(q[3], 1'b1)
    // cd rise, lock loss and fs changes stay sticky; the non-pcm bit was cleared earlier
    rd_reg(BSD_REG_IRQ_ST);
    `CHK(q, 32'he)
    meas(123, 123);
    test_done();
  end
endmodule
`default_nettype wire
